// ==== src/pmc_pkg.sv ====
// Shared constants and types for the power-mode clock controller
package pmc_pkg;

	// Operating modes, one-hot
	typedef enum logic [7:0] {
		PMC_ACT_HI = 8'h01,
		PMC_ACT_MED = 8'h02,
		PMC_SUB_ACT = 8'h04,
		PMC_SLP_HI = 8'h08,
		PMC_SLP_MED = 8'h10,
		PMC_SUB_SLP = 8'h20,
		PMC_WATCH = 8'h40,
		PMC_STANDBY = 8'h80
	} pmc_mode_t;

	// Low-power target encoding on target_sel_i
	localparam logic [2:0] PMC_TGT_SLEEP = 3'h0;
	localparam logic [2:0] PMC_TGT_SUBSLP = 3'h1;
	localparam logic [2:0] PMC_TGT_WATCH = 3'h2;
	localparam logic [2:0] PMC_TGT_STANDBY = 3'h3;
	localparam logic [2:0] PMC_TGT_ACT_HI = 3'h4;
	localparam logic [2:0] PMC_TGT_ACT_MED = 3'h5;
	localparam logic [2:0] PMC_TGT_SUB_ACT = 3'h6;

	// Subclock ratio select: watch clock /2, /4, /8
	localparam logic [1:0] PMC_SUB_DIV2 = 2'h0;
	localparam logic [1:0] PMC_SUB_DIV4 = 2'h1;
	localparam logic [1:0] PMC_SUB_DIV8 = 2'h2;

	// Main oscillator to system clock ratio
	localparam int PMC_SYS_DIV = 2;
	// Medium-speed divide of the system clock, product-specific
	localparam int PMC_MED_DIV = 8;
	localparam int PMC_CNT_W = 4;
	localparam logic [PMC_CNT_W-1:0] PMC_CNT_ONE = 4'h1;
	localparam logic [PMC_CNT_W-1:0] PMC_CNT_ZERO = 4'h0;

	// Example figures: 10 MHz oscillator gives 5 MHz system clock
	localparam int PMC_OSC_KHZ = 10000;
	localparam int PMC_SYS_KHZ = PMC_OSC_KHZ / PMC_SYS_DIV;

endpackage

// ==== src/pmc_div.sv ====
// Enable-pulse divider: one pulse every ratio ticks
`timescale 1ns/100ps
module pmc_div (
	input wire logic mclk_i, // Clock
	input wire logic rst_n_i, // Sync reset, active low
	input wire logic run_i, // Count enable
	input wire logic tick_i, // Input tick
	input wire logic [pmc_pkg::PMC_CNT_W-1:0] ratio_i, // Divide ratio, at least 1
	output logic pulse_o // Output tick
);
	logic [pmc_pkg::PMC_CNT_W-1:0] cnt_q, cnt_d;
	logic pulse_q, pulse_d;

	// Count ticks; clearing when stopped keeps restart phase fixed
	always_comb begin
		cnt_d = cnt_q;
		pulse_d = 1'b0;
		if (!run_i) begin
			cnt_d = pmc_pkg::PMC_CNT_ZERO;
		end else if (tick_i) begin
			if (cnt_q >= ratio_i - pmc_pkg::PMC_CNT_ONE) begin
				cnt_d = pmc_pkg::PMC_CNT_ZERO;
				pulse_d = 1'b1;
			end else begin
				cnt_d = cnt_q + pmc_pkg::PMC_CNT_ONE;
			end
		end
	end

	// Register
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			cnt_q <= pmc_pkg::PMC_CNT_ZERO;
			pulse_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			pulse_q <= pulse_d;
		end
	end

	assign pulse_o = pulse_q;
endmodule

// ==== src/pmc_edge.sv ====
// Rising-edge detector for the sub-oscillator tick
`timescale 1ns/100ps
module pmc_edge (
	input wire logic mclk_i, // Clock
	input wire logic rst_n_i, // Sync reset, active low
	input wire logic lvl_i, // Level input
	output logic rise_o // One-cycle pulse on rising edge
);
	logic lvl_q, lvl_d;

	// Keep last level
	always_comb begin
		lvl_d = lvl_i;
	end

	// Register
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			lvl_q <= 1'b0;
		end else begin
			lvl_q <= lvl_d;
		end
	end

	assign rise_o = lvl_i & ~lvl_q;
endmodule

// ==== src/pmc_top.sv ====
// Power-mode and clock-gating controller top level
// How it works
// [RULE1] Active high-speed clocks the CPU from the system clock, half the main oscillator rate.
// [RULE2] Active medium-speed clocks the CPU from the system clock further divided by a product ratio.
// [RULE3] Subactive stops the main oscillator and clocks the CPU from the divided sub-oscillator.
// [RULE4] Sleep high-speed stops the CPU and clocks peripherals from the full system clock.
// [RULE5] Sleep medium-speed stops the CPU and clocks peripherals from the medium-speed clock.
// [RULE6] Subsleep clocks peripherals from the subclock with the CPU stopped.
// [RULE7] Watch stops the oscillator and CPU and clocks only the timekeeping peripherals.
// [RULE8] In watch every other peripheral gets no clock.
// [RULE9] Standby stops the oscillator, CPU and all peripherals and never writes RAM.
// [RULE10] Modes change only on an interrupt request or the low-power instruction.
// [RULE11] The subclock ratio is the watch clock divided by 2, 4 or 8.
// [RULE12] The CPU runs on one selected clock and one period of it is one state.
// [RULE13] The low-power instruction picks its target from configuration bits.
// [RULE14] An interrupt in a halted mode restarts the CPU before interrupt handling.
`timescale 1ns/100ps
module pmc_top (
	input wire logic mclk_i, // Clock, 100 MHz
	input wire logic rst_n_i, // Sync reset, active low
	input wire logic osc_tick_i, // Main oscillator tick pulse
	input wire logic sub_osc_i, // 32.768 kHz sub-oscillator level
	input wire logic sleep_exec_i, // Low-power instruction pulse
	input wire logic [2:0] target_sel_i, // Target mode configuration
	input wire logic [1:0] sub_div_sel_i, // Subclock ratio select
	input wire logic irq_i, // Enabled interrupt request
	output logic osc_en_o, // Main oscillator run
	output logic cpu_clk_en_o, // CPU state tick
	output logic per_clk_en_o, // General peripheral tick
	output logic time_clk_en_o, // Timekeeping peripheral tick
	output logic ram_we_block_o, // RAM write block
	output logic irq_ack_o, // Wake done, handling may begin
	output logic [7:0] mode_o // Current mode, one-hot
);
	pmc_pkg::pmc_mode_t mode_q, mode_d;
	pmc_pkg::pmc_mode_t run_mode_q, run_mode_d;
	logic osc_en_q, osc_en_d;
	logic cpu_q, cpu_d;
	logic per_q, per_d;
	logic tim_q, tim_d;
	logic ram_q, ram_d;
	logic ack_q, ack_d;
	logic sys_tick, med_tick, sub_rise, wclk_tick, sub_tick;
	logic [pmc_pkg::PMC_CNT_W-1:0] sub_ratio;

	// Mode state: mode_q is the live mode, run_mode_q the running mode to
	// resume from watch or standby. Gating state: one flop per output, so
	// every enable leaves the block glitch-free one cycle after the mode.

	// Decode subclock ratio; unsupported code falls back to /8
	function automatic logic [pmc_pkg::PMC_CNT_W-1:0] sub_ratio_f(input logic [1:0] sel);
		case (sel)
			pmc_pkg::PMC_SUB_DIV2: sub_ratio_f = 4'h2;
			pmc_pkg::PMC_SUB_DIV4: sub_ratio_f = 4'h4;
			default: sub_ratio_f = 4'h8;
		endcase
	endfunction

	// Is the oscillator needed in a mode
	function automatic logic osc_need_f(input pmc_pkg::pmc_mode_t m);
		osc_need_f = (m == pmc_pkg::PMC_ACT_HI) || (m == pmc_pkg::PMC_ACT_MED) ||
			(m == pmc_pkg::PMC_SLP_HI) || (m == pmc_pkg::PMC_SLP_MED);
	endfunction

	// Sleep target keeps the speed of the running mode it leaves
	function automatic pmc_pkg::pmc_mode_t sleep_mode_f(input pmc_pkg::pmc_mode_t m);
		case (m)
			pmc_pkg::PMC_ACT_HI: sleep_mode_f = pmc_pkg::PMC_SLP_HI;
			pmc_pkg::PMC_ACT_MED: sleep_mode_f = pmc_pkg::PMC_SLP_MED;
			default: sleep_mode_f = pmc_pkg::PMC_SUB_SLP;
		endcase
	endfunction

	// Wake target: sleep modes return to their own speed
	// Watch and standby lose the speed, so they use the saved running mode
	function automatic pmc_pkg::pmc_mode_t wake_mode_f(input pmc_pkg::pmc_mode_t m,
		input pmc_pkg::pmc_mode_t r);
		case (m)
			pmc_pkg::PMC_SLP_HI: wake_mode_f = pmc_pkg::PMC_ACT_HI;
			pmc_pkg::PMC_SLP_MED: wake_mode_f = pmc_pkg::PMC_ACT_MED;
			pmc_pkg::PMC_SUB_SLP: wake_mode_f = pmc_pkg::PMC_SUB_ACT;
			default: wake_mode_f = r;
		endcase
	endfunction

	// [RULE11] watch clock ratio
	assign sub_ratio = sub_ratio_f(sub_div_sel_i);

	// [RULE1] system clock is oscillator over two
	// Stopping with the oscillator restarts the phase from zero on wake,
	// at the cost of up to one lost system tick after each restart
	pmc_div u_sys_div (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.run_i(osc_en_q),
		.tick_i(osc_tick_i),
		.ratio_i(4'(pmc_pkg::PMC_SYS_DIV)),
		.pulse_o(sys_tick)
	);

	// [RULE2] medium-speed divide of system clock
	// Runs in every oscillator mode so a switch to medium speed
	// needs no warm-up of its own
	pmc_div u_med_div (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.run_i(osc_en_q),
		.tick_i(sys_tick),
		.ratio_i(4'(pmc_pkg::PMC_MED_DIV)),
		.pulse_o(med_tick)
	);

	// Sub-oscillator edge gives the watch clock tick
	// Detector resets low, matching the idle level, so no false edge
	pmc_edge u_sub_edge (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.lvl_i(sub_osc_i),
		.rise_o(sub_rise)
	);
	assign wclk_tick = sub_rise;

	// [RULE3] subclock from divided sub-oscillator
	// Never stopped: watch keeps timekeeping alive from this divider
	// A ratio change takes effect at the next watch clock tick
	pmc_div u_sub_div (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.run_i(1'b1),
		.tick_i(wclk_tick),
		.ratio_i(sub_ratio),
		.pulse_o(sub_tick)
	);

	// Mode sequencing
	always_comb begin
		mode_d = mode_q;
		run_mode_d = run_mode_q;
		ack_d = 1'b0;
		case (mode_q)
			pmc_pkg::PMC_ACT_HI, pmc_pkg::PMC_ACT_MED, pmc_pkg::PMC_SUB_ACT: begin
				// [RULE10] only instruction leaves a running mode
				if (sleep_exec_i) begin
					run_mode_d = mode_q;
					// [RULE13] target from configuration
					case (target_sel_i)
						pmc_pkg::PMC_TGT_SLEEP: mode_d = sleep_mode_f(mode_q);
						pmc_pkg::PMC_TGT_SUBSLP: mode_d = pmc_pkg::PMC_SUB_SLP;
						pmc_pkg::PMC_TGT_WATCH: mode_d = pmc_pkg::PMC_WATCH;
						pmc_pkg::PMC_TGT_STANDBY: mode_d = pmc_pkg::PMC_STANDBY;
						pmc_pkg::PMC_TGT_ACT_HI: mode_d = pmc_pkg::PMC_ACT_HI;
						pmc_pkg::PMC_TGT_ACT_MED: mode_d = pmc_pkg::PMC_ACT_MED;
						pmc_pkg::PMC_TGT_SUB_ACT: mode_d = pmc_pkg::PMC_SUB_ACT;
						default: mode_d = mode_q;
					endcase
					// Direct moves between running modes keep that as resume mode
					if (target_sel_i >= pmc_pkg::PMC_TGT_ACT_HI && target_sel_i <= pmc_pkg::PMC_TGT_SUB_ACT) begin
						run_mode_d = mode_d;
					end
				end
			end
			pmc_pkg::PMC_SLP_HI, pmc_pkg::PMC_SLP_MED, pmc_pkg::PMC_SUB_SLP,
			pmc_pkg::PMC_WATCH, pmc_pkg::PMC_STANDBY: begin
				// [RULE14] interrupt wakes to running mode
				// The low-power instruction is ignored here, the CPU is stopped
				if (irq_i) begin
					mode_d = wake_mode_f(mode_q, run_mode_q);
					// Ack rises at the wake edge, in the same cycle as the new mode
					ack_d = 1'b1;
				end
			end
			default: begin
				mode_d = pmc_pkg::PMC_ACT_HI;
				run_mode_d = pmc_pkg::PMC_ACT_HI;
			end
		endcase
	end

	// Clock gating per mode; outputs registered for clean enables
	always_comb begin
		osc_en_d = osc_need_f(mode_q);
		cpu_d = 1'b0;
		per_d = 1'b0;
		tim_d = 1'b0;
		ram_d = 1'b0;
		case (mode_q)
			pmc_pkg::PMC_ACT_HI: begin
				// [RULE1] full system clock to CPU
				cpu_d = sys_tick;
				per_d = sys_tick;
				tim_d = sys_tick;
			end
			pmc_pkg::PMC_ACT_MED: begin
				// [RULE2] divided system clock to CPU
				cpu_d = med_tick;
				per_d = med_tick;
				tim_d = med_tick;
			end
			pmc_pkg::PMC_SUB_ACT: begin
				// [RULE3] subclock to CPU, oscillator off
				cpu_d = sub_tick;
				per_d = sub_tick;
				tim_d = sub_tick;
			end
			pmc_pkg::PMC_SLP_HI: begin
				// [RULE4] peripherals on system clock only
				per_d = sys_tick;
				tim_d = sys_tick;
			end
			pmc_pkg::PMC_SLP_MED: begin
				// [RULE5] peripherals on medium clock only
				per_d = med_tick;
				tim_d = med_tick;
			end
			pmc_pkg::PMC_SUB_SLP: begin
				// [RULE6] peripherals on subclock, CPU stopped
				per_d = sub_tick;
				tim_d = sub_tick;
			end
			pmc_pkg::PMC_WATCH: begin
				// [RULE7] timekeeping only on subclock
				tim_d = sub_tick;
				// [RULE8] other peripherals halted
				per_d = 1'b0;
			end
			pmc_pkg::PMC_STANDBY: begin
				// [RULE9] everything stopped, RAM frozen
				ram_d = 1'b1;
			end
			default: begin
				osc_en_d = 1'b1;
			end
		endcase
	end

	// Mode registers; reset lands in active high-speed
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			mode_q <= pmc_pkg::PMC_ACT_HI;
			run_mode_q <= pmc_pkg::PMC_ACT_HI;
			ack_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			run_mode_q <= run_mode_d;
			ack_q <= ack_d;
		end
	end

	// [RULE12] one enable pulse is one CPU state
	// Gating registers; the oscillator runs out of reset so the
	// system divider can start at once
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			osc_en_q <= 1'b1;
			cpu_q <= 1'b0;
			per_q <= 1'b0;
			tim_q <= 1'b0;
			ram_q <= 1'b0;
		end else begin
			osc_en_q <= osc_en_d;
			cpu_q <= cpu_d;
			per_q <= per_d;
			tim_q <= tim_d;
			ram_q <= ram_d;
		end
	end

	// Outputs straight from the flops
	// Consumers must treat the enables as one-cycle qualifiers, not clocks
	assign osc_en_o = osc_en_q;
	assign cpu_clk_en_o = cpu_q;
	assign per_clk_en_o = per_q;
	assign time_clk_en_o = tim_q;
	assign ram_we_block_o = ram_q;
	assign irq_ack_o = ack_q;
	assign mode_o = mode_q;
endmodule

// ==== dv/pmc_top_asserts.sv ====
// Assertion checker for the power-mode clock controller
`timescale 1ns/100ps
module pmc_top_asserts (
	input wire logic mclk_i, // Clock
	input wire logic rst_n_i, // Reset, active low
	input wire logic sleep_exec_i, // Low-power instruction
	input wire logic [2:0] target_sel_i, // Target select
	input wire logic irq_i, // Interrupt request
	input wire logic osc_en_o, // Oscillator run
	input wire logic cpu_clk_en_o, // CPU tick
	input wire logic per_clk_en_o, // Peripheral tick
	input wire logic time_clk_en_o, // Timekeeping tick
	input wire logic ram_we_block_o, // RAM write block
	input wire logic irq_ack_o, // Wake done
	input wire logic [7:0] mode_o // Mode
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);
	// Gating lags the mode by one cycle, so both cycles must agree
	one_hot_a: assert property ($onehot(mode_o))
		else $error("mode not one-hot");
	cpu_stop_a: assert property (|mode_o[7:3] && |$past(mode_o[7:3]) |-> !cpu_clk_en_o)
		else $error("cpu tick in halted mode");
	osc_stop_a: assert property ((mode_o & 8'hC4) != 8'h00 && ($past(mode_o) & 8'hC4) != 8'h00 |-> !osc_en_o)
		else $error("oscillator runs in low mode");
	osc_run_a: assert property ((mode_o & 8'h1B) != 8'h00 && ($past(mode_o) & 8'h1B) != 8'h00 |-> osc_en_o)
		else $error("oscillator stopped in fast mode");
	standby_off_a: assert property (mode_o == 8'h80 && $past(mode_o) == 8'h80
		|-> !per_clk_en_o && !time_clk_en_o && ram_we_block_o)
		else $error("activity in standby");
	watch_per_a: assert property (mode_o == 8'h40 && $past(mode_o) == 8'h40 |-> !per_clk_en_o)
		else $error("peripheral tick in watch");
	mode_hold_a: assert property (!sleep_exec_i && !irq_i |=> $stable(mode_o))
		else $error("mode changed without cause");
	wake_run_a: assert property (irq_i && |mode_o[7:3] |=> |mode_o[2:0] && irq_ack_o)
		else $error("no wake on interrupt");
	ack_cause_a: assert property (irq_ack_o |-> $past(irq_i) && |$past(mode_o[7:3]))
		else $error("ack without wake");
	sleep_tgt_a: assert property (sleep_exec_i && mode_o == 8'h01 && target_sel_i == 3'h0 |=> mode_o == 8'h08)
		else $error("sleep target not taken");
endmodule
bind pmc_top pmc_top_asserts chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sleep_exec_i(sleep_exec_i),
	.target_sel_i(target_sel_i), .irq_i(irq_i), .osc_en_o(osc_en_o), .cpu_clk_en_o(cpu_clk_en_o),
	.per_clk_en_o(per_clk_en_o), .time_clk_en_o(time_clk_en_o), .ram_we_block_o(ram_we_block_o),
	.irq_ack_o(irq_ack_o), .mode_o(mode_o));

// ==== dv/pmc_far_model.sv ====
// Oscillators and clock consumers on the controller's far side
`timescale 1ns/100ps
module pmc_far_model #(parameter int SUB_HALF = 4) (
	input wire logic mclk_i, // Clock
	input wire logic osc_en_i, // Oscillator run
	input wire logic cpu_i, // CPU tick
	input wire logic per_i, // Peripheral tick
	input wire logic time_i, // Timekeeping tick
	input wire logic clr_i, // Clear counts
	output logic osc_tick_o = 1'b0, // Main oscillator tick
	output logic sub_osc_o = 1'b0, // Sub-oscillator, shortened period
	output int cpu_n_o = 0, // CPU ticks seen
	output int per_n_o = 0, // Peripheral ticks seen
	output int time_n_o = 0 // Timekeeping ticks seen
);
	int oc = 0;
	int sc = 0;
	// Oscillator stops when disabled, as a real crystal would
	always @(posedge mclk_i) begin
		oc <= (osc_en_i && oc < 9) ? oc + 1 : 0;
		osc_tick_o <= osc_en_i && oc == 9;
		sc <= (sc == SUB_HALF - 1) ? 0 : sc + 1;
		sub_osc_o <= (sc == SUB_HALF - 1) ? !sub_osc_o : sub_osc_o;
		cpu_n_o <= clr_i ? 0 : cpu_n_o + int'(cpu_i);
		per_n_o <= clr_i ? 0 : per_n_o + int'(per_i);
		time_n_o <= clr_i ? 0 : time_n_o + int'(time_i);
	end
endmodule

// ==== dv/test_power_mode_clock_controller.sv ====
// Self-checking testbench for the power-mode clock controller
`timescale 1ns/100ps
module test_power_mode_clock_controller;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic sexe = 1'b0;
	logic [2:0] tsel = 3'h0;
	logic [1:0] dsel = 2'h0;
	logic irq = 1'b0;
	logic clr = 1'b0;
	logic osc_tick, sub_osc, osc_en, cpu_en, per_en, time_en, ram_blk, ack;
	logic [7:0] mode;
	int cpu_n, per_n, time_n;
	int errors = 0;
	int comparisons = 0;
	// Clock, 100 MHz
	always #5 mclk_i = ~mclk_i;
	pmc_top uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .osc_tick_i(osc_tick), .sub_osc_i(sub_osc),
		.sleep_exec_i(sexe), .target_sel_i(tsel), .sub_div_sel_i(dsel), .irq_i(irq), .osc_en_o(osc_en),
		.cpu_clk_en_o(cpu_en), .per_clk_en_o(per_en), .time_clk_en_o(time_en), .ram_we_block_o(ram_blk),
		.irq_ack_o(ack), .mode_o(mode));
	pmc_far_model far (.mclk_i(mclk_i), .osc_en_i(osc_en), .cpu_i(cpu_en), .per_i(per_en), .time_i(time_en),
		.clr_i(clr), .osc_tick_o(osc_tick), .sub_osc_o(sub_osc), .cpu_n_o(cpu_n), .per_n_o(per_n),
		.time_n_o(time_n));
	task automatic chk_val(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	// Tick counts allow one of slack for divider phase
	task automatic chk_cnt(input string n, input int e, input int g);
		comparisons++;
		if (g < e - 1 || g > e + 1) begin
			errors++;
			$display("MISMATCH %s expected %0d seen %0d", n, e, g);
		end
	endtask
	task automatic go(input logic [2:0] t);
		@(posedge mclk_i);
		sexe <= 1'b1;
		tsel <= t;
		@(posedge mclk_i);
		sexe <= 1'b0;
		repeat (3) @(posedge mclk_i);
		#1;
	endtask
	task automatic wake(input logic [7:0] m);
		@(posedge mclk_i);
		irq <= 1'b1;
		@(posedge mclk_i);
		irq <= 1'b0;
		#1;
		chk_val("ack", 8'h01, {7'h00, ack});
		chk_val("wake mode", m, mode);
	endtask
	task automatic meas(input int n);
		@(posedge mclk_i);
		clr <= 1'b1;
		@(posedge mclk_i);
		clr <= 1'b0;
		repeat (n - 1) @(posedge mclk_i);
		#1;
	endtask
	task automatic t_act();
		chk_val("reset mode", 8'h01, mode);
		meas(400);
		chk_cnt("cpu hi", 20, cpu_n);
		chk_cnt("per hi", 20, per_n);
		$display("test active done");
	endtask
	task automatic t_halt();
		logic [2:0] tg[3] = '{3'h0, 3'h2, 3'h3};
		logic [7:0] md[3] = '{8'h08, 8'h40, 8'h80};
		int pn[3] = '{20, 0, 0};
		for (int i = 0; i < 3; i++) begin
			go(tg[i]);
			chk_val("halt mode", md[i], mode);
			chk_val("osc run", {7'h00, i == 0}, {7'h00, osc_en});
			meas(400);
			chk_cnt("cpu halted", 0, cpu_n);
			chk_cnt("per halted", pn[i], per_n);
			chk_val("time on", {7'h00, i != 2}, {7'h00, time_n > 0});
			chk_val("ram block", {7'h00, i == 2}, {7'h00, ram_blk});
			wake(8'h01);
		end
		$display("test halt done");
	endtask
	task automatic t_med();
		go(3'h5);
		meas(800);
		chk_cnt("cpu med", 5, cpu_n);
		go(3'h0);
		chk_val("sleep med", 8'h10, mode);
		meas(800);
		chk_cnt("per med", 5, per_n);
		wake(8'h02);
		go(3'h4);
		chk_val("back hi", 8'h01, mode);
		$display("test medium done");
	endtask
	// Sub-oscillator rises every 8 cycles in the model
	task automatic t_sub();
		for (int d = 0; d < 3; d++) begin
			@(posedge mclk_i);
			dsel <= 2'(d);
			go(3'h6);
			chk_val("subact", 8'h04, mode);
			meas(640);
			chk_cnt("cpu sub", 640 / (16 << d), cpu_n);
			chk_val("osc sub", 8'h00, {7'h00, osc_en});
			go(3'h0);
			meas(640);
			chk_cnt("cpu subslp", 0, cpu_n);
			chk_cnt("per subslp", 640 / (16 << d), per_n);
			wake(8'h04);
			go(3'h4);
		end
		$display("test subclock done");
	endtask
	task automatic t_refuse();
		@(posedge mclk_i);
		irq <= 1'b1;
		@(posedge mclk_i);
		irq <= 1'b0;
		#1;
		chk_val("ack running", 8'h00, {7'h00, ack});
		chk_val("irq ignored", 8'h01, mode);
		go(3'h7);
		chk_val("target 7", 8'h01, mode);
		go(3'h3);
		go(3'h0);
		chk_val("exec standby", 8'h80, mode);
		wake(8'h01);
		// Watch entered from subactive resumes subactive; spare select is /8
		@(posedge mclk_i);
		dsel <= 2'h3;
		go(3'h6);
		go(3'h2);
		chk_val("watch from sub", 8'h40, mode);
		meas(640);
		chk_cnt("time watch", 10, time_n);
		wake(8'h04);
		go(3'h4);
		go(3'h1);
		chk_val("subsleep tgt", 8'h20, mode);
		wake(8'h04);
		go(3'h4);
		chk_val("back hi 2", 8'h01, mode);
		$display("test refuse done");
	endtask
	task automatic finish_test();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		@(posedge mclk_i);
		#1;
		t_act();
		t_halt();
		t_med();
		t_sub();
		t_refuse();
		finish_test();
	end
	// Watchdog, run needs about 7800 cycles
	initial begin
		repeat (30000) @(posedge mclk_i);
		errors++;
		finish_test();
	end
endmodule
